// ### common/pamp_pkg.sv
// How it works
// [R01] write-done bit 6, resets to one
// [R02] read-done bit 5, software polls it
// [R03] byte-enable LSB write starts table access
// [R04] force-miss: single entry, match means miss
// [R05] no force-miss: ruleset match means hit
// [R06] rx sniff bit 6 mirrors received packets
// [R07] tx sniff bit 5 mirrors transmitted packets
// [R08] bit 1 makes port the sniffer
// [R09] software sets global mirroring too
// [R10] software sets one priority bit only
// [R11] bit 7 picks highest classified priority
// [R12] bit 6 ORs all classified priorities
// [R13] bit 4 enables MAC priority class
// [R14] bit 3 enables VLAN priority class
// [R15] bit 2 enables 802.1p priority class
// [R16] bit 1 enables Diffserv priority class
// [R17] bit 0 enables ACL priority class
// [R18] start clears flag, finish sets; reserved zero
package pamp_pkg;
  // ********************************
  // register map, low 12 address bits
  // ********************************
  localparam logic [11:0] OFS_BE_LSB = 12'h611;
  localparam logic [11:0] OFS_ACL_CTRL = 12'h612;
  localparam logic [11:0] OFS_RING_CTRL = 12'h613;
  localparam logic [11:0] OFS_MIRROR = 12'h800;
  localparam logic [11:0] OFS_PRIO = 12'h801;
  localparam logic [11:0] OFS_BE_MSB = 12'h610;
  localparam int PORT_LSB = 12;
  // ********************************
  // field positions
  // ********************************
  localparam int ACL_WR_DONE = 6;
  localparam int ACL_RD_DONE = 5;
  localparam int ACL_DIR = 4;
  localparam int RING_FORCE_MISS = 0;
  localparam int MIR_RX = 6;
  localparam int MIR_TX = 5;
  localparam int MIR_SNIFFER = 1;
  localparam int PRI_HIGHEST = 7;
  localparam int PRI_OR = 6;
  localparam int NUM_SRC = 5;
  localparam int PRIO_W = 3;
  // ********************************
  // reset values and writable masks
  // ********************************
  localparam logic [7:0] ACL_CTRL_RST = 8'h00;
  localparam logic [7:0] ACL_CTRL_WMASK = 8'h1f;
  localparam logic [7:0] RING_WMASK = 8'hff;
  localparam logic [7:0] MIRROR_WMASK = 8'h62;
  localparam logic [7:0] PRIO_WMASK = 8'hdf;
  localparam logic [7:0] REG_RST = 8'h00;
endpackage : pamp_pkg

// ### common/pamp_acl_if.sv
`timescale 1ns/100ps
// table access handshake between register bank and engine
interface pamp_acl_if;
  logic start;
  logic wr_dir;
  logic [3:0] idx;
  logic [15:0] be;
  logic busy;
  logic wr_done;
  logic rd_done;
  modport ctrl (output start, wr_dir, idx, be, input busy, wr_done, rd_done);
  modport eng (input start, wr_dir, idx, be, output busy, wr_done, rd_done);
endinterface : pamp_acl_if

// ### rtl/pamp_acl_engine.sv
`timescale 1ns/100ps
module pamp_acl_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  pamp_acl_if.eng acl,
  output logic table_req_o,
  output logic table_we_o,
  output logic [3:0] table_idx_o,
  output logic [15:0] table_be_o,
  input wire logic table_ack_i
);
  import pamp_pkg::*;

  typedef enum logic {ST_IDLE, ST_BUSY} pamp_eng_state_type;

  pamp_eng_state_type state_r, state_nxt;
  logic we_r, we_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [15:0] be_r, be_nxt;
  logic wr_done_r, wr_done_nxt;
  logic rd_done_r, rd_done_nxt;

  // ********************************
  // sequencer
  // ********************************
  // start latches the request; no enabled byte finishes at once
  always_comb begin
    state_nxt = state_r;
    we_nxt = we_r;
    idx_nxt = idx_r;
    be_nxt = be_r;
    wr_done_nxt = wr_done_r;
    rd_done_nxt = rd_done_r;
    unique case (state_r)
      ST_IDLE: begin
        if (acl.start) begin // R03
          we_nxt = acl.wr_dir;
          idx_nxt = acl.idx;
          be_nxt = acl.be;
          if (acl.be != 16'h0000) begin
            state_nxt = ST_BUSY;
            if (acl.wr_dir) begin
              wr_done_nxt = 1'b0; // R18
            end else begin
              rd_done_nxt = 1'b0; // R18
            end
          end
        end
      end
      ST_BUSY: begin
        if (table_ack_i) begin
          state_nxt = ST_IDLE;
          if (we_r) begin
            wr_done_nxt = 1'b1; // R01
          end else begin
            rd_done_nxt = 1'b1; // R02
          end
        end
      end
    endcase
  end

  // state registers, done flags reset to complete
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      we_r <= 1'b0;
      idx_r <= 4'h0;
      be_r <= 16'h0000;
      wr_done_r <= 1'b1; // R01
      rd_done_r <= 1'b1; // R02
    end else begin
      state_r <= state_nxt;
      we_r <= we_nxt;
      idx_r <= idx_nxt;
      be_r <= be_nxt;
      wr_done_r <= wr_done_nxt;
      rd_done_r <= rd_done_nxt;
    end
  end

  // table side, request held until acknowledged
  assign table_req_o = (state_r == ST_BUSY);
  assign table_we_o = we_r;
  assign table_idx_o = idx_r;
  assign table_be_o = be_r; // R03
  assign acl.busy = (state_r == ST_BUSY);
  assign acl.wr_done = wr_done_r;
  assign acl.rd_done = rd_done_r;

  // ********************************
  // checks
  // ********************************
  property p_done_on_ack;
    @(posedge clk_i) disable iff (rst_i)
      table_req_o && table_ack_i |=> (we_r ? wr_done_r : rd_done_r) && !table_req_o;
  endproperty
  a_done_on_ack: assert property (p_done_on_ack) else $error("done flag not set after ack"); // R01

  property p_pending_until_ack;
    @(posedge clk_i) disable iff (rst_i)
      table_req_o && !table_ack_i |=> table_req_o && $stable(idx_r) && $stable(be_r);
  endproperty
  a_pending_until_ack: assert property (p_pending_until_ack) else $error("request dropped before ack"); // R03
endmodule : pamp_acl_engine

// ### rtl/pamp_port_ctrl.sv
`timescale 1ns/100ps
module pamp_port_ctrl #(
  parameter logic [3:0] PORT_NUM = 4'h1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // byte-wide management register port
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // byte enables held by the data-register bank
  input wire logic [7:0] be_msb_i,
  // acl table access
  output logic table_req_o,
  output logic table_we_o,
  output logic [3:0] table_idx_o,
  output logic [15:0] table_be_o,
  input wire logic table_ack_i,
  // ring-protocol filtering
  input wire logic ring_entry_match_i,
  input wire logic ring_ruleset_match_i,
  output logic ring_single_entry_o,
  output logic ring_hit_o,
  // mirroring
  output logic rx_sniff_o,
  output logic tx_sniff_o,
  output logic sniffer_port_o,
  // priority classification, source k at bit k
  input wire logic [pamp_pkg::NUM_SRC-1:0] cls_vld_i,
  input wire logic [pamp_pkg::NUM_SRC*pamp_pkg::PRIO_W-1:0] cls_prio_i,
  input wire logic [pamp_pkg::PRIO_W-1:0] default_prio_i,
  output logic [pamp_pkg::PRIO_W-1:0] prio_o,
  output logic prio_from_cls_o
);
  import pamp_pkg::*;

  // port number must name one of the seven switch ports
  if (PORT_NUM < 4'h1 || PORT_NUM > 4'h7) begin : g_port_check
    $error("PORT_NUM must be 1 to 7");
  end

  // ********************************
  // helpers
  // ********************************
  function automatic logic [PRIO_W-1:0] prio_of(
    input logic [NUM_SRC*PRIO_W-1:0] all, input int k);
    prio_of = all[k*PRIO_W +: PRIO_W];
  endfunction : prio_of

  function automatic logic [PRIO_W-1:0] max_prio(
    input logic [PRIO_W-1:0] a, input logic [PRIO_W-1:0] b);
    max_prio = (a > b) ? a : b;
  endfunction : max_prio

  function automatic logic hit(input logic [15:0] a, input logic [11:0] ofs);
    hit = (a[15:PORT_LSB] == PORT_NUM) && (a[PORT_LSB-1:0] == ofs);
  endfunction : hit

  // ********************************
  // control registers
  // ********************************
  pamp_acl_if acl ();

  logic [7:0] acl_ctrl_r, acl_ctrl_nxt;
  logic [7:0] ring_r, ring_nxt;
  logic [7:0] mirror_r, mirror_nxt;
  logic [7:0] prio_ctrl_r, prio_ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // software writes, masked to writable bits
  always_comb begin
    acl_ctrl_nxt = acl_ctrl_r;
    ring_nxt = ring_r;
    mirror_nxt = mirror_r;
    prio_ctrl_nxt = prio_ctrl_r;
    if (wr_i && hit(addr_i, OFS_ACL_CTRL)) begin
      acl_ctrl_nxt = wdata_i & ACL_CTRL_WMASK;
    end
    if (wr_i && hit(addr_i, OFS_RING_CTRL)) begin
      ring_nxt = wdata_i & RING_WMASK;
    end
    if (wr_i && hit(addr_i, OFS_MIRROR)) begin
      mirror_nxt = wdata_i & MIRROR_WMASK; // R18
    end
    if (wr_i && hit(addr_i, OFS_PRIO)) begin
      prio_ctrl_nxt = wdata_i & PRIO_WMASK; // R18
    end
  end

  // read mux, status bits live, unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_i) begin
      if (hit(addr_i, OFS_ACL_CTRL)) begin
        rdata_nxt = acl_ctrl_r;
        rdata_nxt[ACL_WR_DONE] = acl.wr_done; // R01
        rdata_nxt[ACL_RD_DONE] = acl.rd_done; // R02
      end else if (hit(addr_i, OFS_RING_CTRL)) begin
        rdata_nxt = ring_r;
      end else if (hit(addr_i, OFS_MIRROR)) begin
        rdata_nxt = mirror_r;
      end else if (hit(addr_i, OFS_PRIO)) begin
        rdata_nxt = prio_ctrl_r;
      end
    end
  end

  // register bank flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acl_ctrl_r <= ACL_CTRL_RST;
      ring_r <= REG_RST;
      mirror_r <= REG_RST;
      prio_ctrl_r <= REG_RST;
      rdata_r <= 8'h00;
    end else begin
      acl_ctrl_r <= acl_ctrl_nxt;
      ring_r <= ring_nxt;
      mirror_r <= mirror_nxt;
      prio_ctrl_r <= prio_ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // ********************************
  // table access
  // ********************************
  // write to byte-enable LSB launches the access
  assign acl.start = wr_i && hit(addr_i, OFS_BE_LSB); // R03
  assign acl.wr_dir = acl_ctrl_r[ACL_DIR];
  assign acl.idx = acl_ctrl_r[3:0];
  assign acl.be = {be_msb_i, wdata_i}; // R03

  pamp_acl_engine u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .acl(acl),
    .table_req_o(table_req_o),
    .table_we_o(table_we_o),
    .table_idx_o(table_idx_o),
    .table_be_o(table_be_o),
    .table_ack_i(table_ack_i)
  );

  // ********************************
  // ring filter and mirroring
  // ********************************
  logic ring_hit_r, ring_hit_nxt;

  // force-miss turns an entry match into a miss
  always_comb begin
    if (ring_r[RING_FORCE_MISS]) begin
      ring_hit_nxt = 1'b0; // R04
    end else begin
      ring_hit_nxt = ring_ruleset_match_i; // R05
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_hit_r <= 1'b0;
    end else begin
      ring_hit_r <= ring_hit_nxt;
    end
  end

  assign ring_hit_o = ring_hit_r;
  assign ring_single_entry_o = ring_r[RING_FORCE_MISS]; // R04
  assign rx_sniff_o = mirror_r[MIR_RX]; // R06
  assign tx_sniff_o = mirror_r[MIR_TX]; // R07
  assign sniffer_port_o = mirror_r[MIR_SNIFFER]; // R08

  // ********************************
  // priority classification
  // ********************************
  logic [PRIO_W-1:0] prio_r, prio_nxt;
  logic from_cls_r, from_cls_nxt;
  logic [NUM_SRC-1:0] use_src;

  // enable bits 4..0: mac, vlan, 802.1p, diffserv, acl
  assign use_src = cls_vld_i & prio_ctrl_r[NUM_SRC-1:0]; // R13 R14 R15 R16 R17

  // highest, or-ed, else first source from bit 4 down
  always_comb begin
    prio_nxt = default_prio_i;
    from_cls_nxt = |use_src;
    if (prio_ctrl_r[PRI_HIGHEST]) begin
      prio_nxt = '0;
      for (int k = 0; k < NUM_SRC; k++) begin
        if (use_src[k]) begin
          prio_nxt = max_prio(prio_nxt, prio_of(cls_prio_i, k)); // R11
        end
      end
    end else if (prio_ctrl_r[PRI_OR]) begin
      prio_nxt = '0;
      for (int k = 0; k < NUM_SRC; k++) begin
        if (use_src[k]) begin
          prio_nxt = prio_nxt | prio_of(cls_prio_i, k); // R12
        end
      end
    end else begin
      for (int k = 0; k < NUM_SRC; k++) begin
        if (use_src[k]) begin
          prio_nxt = prio_of(cls_prio_i, k);
        end
      end
    end
    if (!(|use_src)) begin
      prio_nxt = default_prio_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_r <= '0;
      from_cls_r <= 1'b0;
    end else begin
      prio_r <= prio_nxt;
      from_cls_r <= from_cls_nxt;
    end
  end

  assign prio_o = prio_r;
  assign prio_from_cls_o = from_cls_r;

  // ********************************
  // checks
  // ********************************
  property p_wr_pending;
    @(posedge clk_i) disable iff (rst_i)
      acl.start && acl.wr_dir && !acl.busy && acl.be != 16'h0000 |=> !acl.wr_done && acl.rd_done == $past(acl.rd_done);
  endproperty
  a_wr_pending: assert property (p_wr_pending) else $error("write flag not cleared on start"); // R01

  property p_rd_pending;
    @(posedge clk_i) disable iff (rst_i)
      acl.start && !acl.wr_dir && !acl.busy && acl.be != 16'h0000 |=> !acl.rd_done ##0 table_req_o;
  endproperty
  a_rd_pending: assert property (p_rd_pending) else $error("read flag not cleared on start"); // R02

  property p_start_be;
    @(posedge clk_i) disable iff (rst_i)
      acl.start && !acl.busy && acl.be != 16'h0000 |=> table_be_o == $past(acl.be) && table_idx_o == $past(acl.idx);
  endproperty
  a_start_be: assert property (p_start_be) else $error("table access not launched"); // R03

  property p_force_miss;
    @(posedge clk_i) disable iff (rst_i)
      ring_r[RING_FORCE_MISS] |=> !ring_hit_o;
  endproperty
  a_force_miss: assert property (p_force_miss) else $error("forced miss reported a hit"); // R04

  property p_ruleset_hit;
    @(posedge clk_i) disable iff (rst_i)
      !ring_r[RING_FORCE_MISS] && ring_ruleset_match_i |=> ring_hit_o;
  endproperty
  a_ruleset_hit: assert property (p_ruleset_hit) else $error("ruleset match not a hit"); // R05

  property p_rx_sniff;
    @(posedge clk_i) disable iff (rst_i)
      wr_i && hit(addr_i, OFS_MIRROR) |=> rx_sniff_o == $past(wdata_i[MIR_RX]) && tx_sniff_o == $past(wdata_i[MIR_TX]);
  endproperty
  a_rx_sniff: assert property (p_rx_sniff) else $error("sniff enables not taken"); // R06 R07

  property p_sniffer;
    @(posedge clk_i) disable iff (rst_i)
      wr_i && hit(addr_i, OFS_MIRROR) |=> sniffer_port_o == $past(wdata_i[MIR_SNIFFER]) && mirror_r[0] == 1'b0;
  endproperty
  a_sniffer: assert property (p_sniffer) else $error("sniffer bit not taken"); // R08

  property p_or_prio;
    @(posedge clk_i) disable iff (rst_i)
      prio_ctrl_r[PRI_OR] && !prio_ctrl_r[PRI_HIGHEST] && use_src == 5'h1f
        |=> prio_o == $past(cls_prio_i[2:0] | cls_prio_i[5:3] | cls_prio_i[8:6] | cls_prio_i[11:9] | cls_prio_i[14:12]);
  endproperty
  a_or_prio: assert property (p_or_prio) else $error("or-ed priority wrong"); // R12

  property p_high_prio;
    @(posedge clk_i) disable iff (rst_i)
      prio_ctrl_r[PRI_HIGHEST] && use_src[0] && use_src[4] |=> prio_o >= $past(cls_prio_i[2:0]) && prio_o >= $past(cls_prio_i[14:12]);
  endproperty
  a_high_prio: assert property (p_high_prio) else $error("highest priority not selected"); // R11

  property p_no_src;
    @(posedge clk_i) disable iff (rst_i)
      use_src == 5'h00 |=> prio_o == $past(default_prio_i) && !prio_from_cls_o;
  endproperty
  a_no_src: assert property (p_no_src) else $error("disabled source used"); // R13 R14 R15 R16 R17

  property p_acl_rsvd;
    @(posedge clk_i) disable iff (rst_i)
      rd_i && hit(addr_i, OFS_ACL_CTRL) |=> !rdata_o[7] && rdata_o[ACL_WR_DONE] == $past(acl.wr_done)
        && rdata_o[ACL_RD_DONE] == $past(acl.rd_done);
  endproperty
  a_acl_rsvd: assert property (p_acl_rsvd) else $error("acl control read back wrong"); // R01 R02 R18

  property p_mirror_rsvd;
    @(posedge clk_i) disable iff (rst_i)
      rd_i && hit(addr_i, OFS_MIRROR) |=> (rdata_o & ~MIRROR_WMASK) == 8'h00;
  endproperty
  a_mirror_rsvd: assert property (p_mirror_rsvd) else $error("reserved mirror bits not zero"); // R18
endmodule : pamp_port_ctrl

// ### tb/pamp_port_ctrl_tb.sv
`timescale 1ns/100ps
module pamp_port_ctrl_tb;
  import pamp_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  localparam logic [3:0] PORT = 4'h3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] be_msb_i = 8'h00;
  logic table_ack_i = 1'b0;
  logic ring_entry_match_i = 1'b0;
  logic ring_ruleset_match_i = 1'b0;
  logic [4:0] cls_vld_i = 5'h00;
  logic [14:0] cls_prio_i = {3'h2, 3'h5, 3'h1, 3'h4, 3'h3};
  logic [2:0] default_prio_i = 3'h6;
  logic [7:0] rdata_o;
  logic table_req_o, table_we_o, ring_single_entry_o, ring_hit_o;
  logic rx_sniff_o, tx_sniff_o, sniffer_port_o, prio_from_cls_o;
  logic [3:0] table_idx_o;
  logic [15:0] table_be_o;
  logic [2:0] prio_o;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  pamp_port_ctrl #(.PORT_NUM(PORT)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .be_msb_i(be_msb_i), .table_req_o(table_req_o),
    .table_we_o(table_we_o), .table_idx_o(table_idx_o), .table_be_o(table_be_o), .table_ack_i(table_ack_i),
    .ring_entry_match_i(ring_entry_match_i), .ring_ruleset_match_i(ring_ruleset_match_i),
    .ring_single_entry_o(ring_single_entry_o), .ring_hit_o(ring_hit_o), .rx_sniff_o(rx_sniff_o),
    .tx_sniff_o(tx_sniff_o), .sniffer_port_o(sniffer_port_o), .cls_vld_i(cls_vld_i), .cls_prio_i(cls_prio_i),
    .default_prio_i(default_prio_i), .prio_o(prio_o), .prio_from_cls_o(prio_from_cls_o));

  // clock and hang guard
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [15:0] ad(input logic [11:0] ofs);
    return {PORT, ofs};
  endfunction : ad

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 wr_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_i);
    #1 wr_i = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1 rd_i = 1'b1;
    addr_i = a;
    @(posedge clk_i);
    #1 rd_i = 1'b0;
    chk(rdata_o, exp);
  endtask : reg_rd

  // expected priority: {from classifier, value}
  function automatic logic [3:0] exp_prio(input logic [7:0] ctl, input logic [4:0] vld);
    logic [2:0] r;
    logic hit;
    r = default_prio_i;
    hit = 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (ctl[k] && vld[k]) begin
        if (!hit) r = cls_prio_i[3*k +: 3];
        else if (ctl[7]) r = (cls_prio_i[3*k +: 3] > r) ? cls_prio_i[3*k +: 3] : r;
        else if (ctl[6]) r = r | cls_prio_i[3*k +: 3];
        else r = cls_prio_i[3*k +: 3];
        hit = 1'b1;
      end
    end
    return {hit, r};
  endfunction : exp_prio

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_and_masks();
    reg_rd(ad(OFS_ACL_CTRL), 8'h60);
    reg_rd(ad(OFS_RING_CTRL), 8'h00);
    reg_rd(ad(OFS_MIRROR), 8'h00);
    reg_rd(ad(OFS_PRIO), 8'h00);
    reg_wr(ad(OFS_ACL_CTRL), 8'hff);
    reg_rd(ad(OFS_ACL_CTRL), 8'h7f);
    reg_wr(ad(OFS_RING_CTRL), 8'hfe);
    reg_rd(ad(OFS_RING_CTRL), 8'hfe);
    reg_wr(ad(OFS_PRIO), 8'hff);
    reg_rd(ad(OFS_PRIO), 8'hdf);
    reg_wr({4'h5, OFS_PRIO}, 8'h00);
    reg_rd(ad(OFS_PRIO), 8'hdf);
    reg_rd({4'h5, OFS_PRIO}, 8'h00);
    reg_rd(ad(12'h805), 8'h00);
  endtask : t_reset_and_masks

  task automatic t_mirror();
    logic [7:0] v [4] = '{8'hff, 8'h40, 8'h20, 8'h02};
    foreach (v[i]) begin
      // global mirroring setup sits outside this block
      reg_wr(ad(OFS_MIRROR), v[i]);
      reg_rd(ad(OFS_MIRROR), v[i] & 8'h62);
      chk(rx_sniff_o, v[i][6]);
      chk(tx_sniff_o, v[i][5]);
      chk(sniffer_port_o, v[i][1]);
    end
  endtask : t_mirror

  task automatic t_table(input logic dir, input logic [3:0] idx, input logic [7:0] msb, input logic [7:0] lsb);
    logic [7:0] busy_st;
    busy_st = dir ? 8'h20 : 8'h40;
    be_msb_i = msb;
    reg_wr(ad(OFS_ACL_CTRL), {3'h0, dir, idx});
    reg_wr(ad(OFS_BE_LSB), lsb);
    chk({table_req_o, table_we_o, table_idx_o}, {10'h0, 1'b1, dir, idx});
    chk(table_be_o, {msb, lsb});
    reg_rd(ad(OFS_ACL_CTRL), busy_st | {3'h0, dir, idx});
    reg_wr(ad(OFS_BE_LSB), ~lsb);
    be_msb_i = ~msb;
    repeat (3) @(posedge clk_i);
    #1 chk({table_req_o, table_we_o, table_idx_o}, {10'h0, 1'b1, dir, idx});
    chk(table_be_o, {msb, lsb});
    table_ack_i = 1'b1;
    @(posedge clk_i);
    #1 table_ack_i = 1'b0;
    chk(table_req_o, 1'b0);
    reg_rd(ad(OFS_ACL_CTRL), {3'h3, dir, idx});
  endtask : t_table

  task automatic t_no_enables();
    be_msb_i = 8'h00;
    reg_wr(ad(OFS_BE_LSB), 8'h00);
    chk(table_req_o, 1'b0);
    reg_rd(ad(OFS_ACL_CTRL), 8'h6a);
  endtask : t_no_enables

  task automatic t_ring();
    logic [1:0] c [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    foreach (c[i]) begin
      reg_wr(ad(OFS_RING_CTRL), {7'h55, c[i][1]});
      ring_ruleset_match_i = c[i][0];
      ring_entry_match_i = c[i][0];
      repeat (2) @(posedge clk_i);
      #1 chk(ring_single_entry_o, c[i][1]);
      chk(ring_hit_o, c[i][0] & ~c[i][1]);
    end
  endtask : t_ring

  task automatic t_priority();
    // one bit at a time first, then mixed settings to probe bit 7 and bit 6
    logic [7:0] ctl [11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h1f, 8'h9f, 8'h5f, 8'hdf, 8'h8a};
    logic [4:0] vld [3] = '{5'h1f, 5'h0a, 5'h00};
    foreach (vld[j]) begin
      cls_vld_i = vld[j];
      foreach (ctl[i]) begin
        reg_wr(ad(OFS_PRIO), ctl[i]);
        repeat (2) @(posedge clk_i);
        #1 chk({prio_from_cls_o, prio_o}, exp_prio(ctl[i], vld[j]));
      end
    end
  endtask : t_priority

  // ****************************************
  // main sequence and verdict
  // ****************************************
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // reset, then every scenario in turn
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_reset_and_masks();
    t_mirror();
    t_table(1'b1, 4'h5, 8'ha5, 8'h3c);
    t_table(1'b0, 4'ha, 8'h80, 8'h01);
    t_no_enables();
    t_ring();
    t_priority();
    end_of_test();
  end
endmodule : pamp_port_ctrl_tb
